// >>> hw/pcg_consts.vh
// Offsets, field positions, reset values and timing counts for the clock generator.
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH

`define PCG_CLK_PERIOD_NS 100
`define PCG_ADDR_W 32

`define PCG_OFS_CSR 32'h01B7C100
`define PCG_OFS_MULT 32'h01B7C110
`define PCG_OFS_DIV0 32'h01B7C114
`define PCG_OFS_DIV1 32'h01B7C118
`define PCG_OFS_DIV2 32'h01B7C11C
`define PCG_OFS_DIV3 32'h01B7C120
`define PCG_OFS_OSCDIV 32'h01B7C124
`define PCG_OFS_DEVCONF 32'h01B7C128
`define PCG_OFS_MEMCTL 32'h01B7C12C

`define PCG_CSR_PATH 0
`define PCG_CSR_PWRDN 1
`define PCG_CSR_RSVD 2
`define PCG_CSR_RST 3
`define PCG_CSR_STABLE 6
`define PCG_DIV_EN 15
`define PCG_DEVCONF_SRC 4
`define PCG_MEMCTL_CKB 3
`define PCG_MEMCTL_MEM 5

`define PCG_RST_MULT 5'h07
`define PCG_RST_DIV0 5'h00
`define PCG_RST_DIV1 5'h00
`define PCG_RST_DIV2 5'h01
`define PCG_RST_DIV3 5'h01
`define PCG_RST_OSCDIV 5'h00
`define PCG_MULT_MIN 5'h04
`define PCG_MULT_MAX 5'h19

`define PCG_STABLE_CYCLES 16'h0100
`define PCG_RESET_TIME_NS 125
`define PCG_LOCK_TYP_NS 75000
`define PCG_LOCK_MAX_NS 187500
`define PCG_RESET_CYCLES ((`PCG_RESET_TIME_NS+`PCG_CLK_PERIOD_NS-1)/`PCG_CLK_PERIOD_NS)
`define PCG_LOCK_CYCLES (`PCG_LOCK_TYP_NS/`PCG_CLK_PERIOD_NS)

`endif

// >>> hw/pcg_divider.v
// Programmable clock-enable divider, ratio code+1 from /1 to /32.
`timescale 1ns/1ps
`default_nettype none
module pcg_divider (
    input wire clk_in,
    input wire reset_in,
    input wire tick_in,
    input wire enable_in,
    input wire [4:0] ratio_in,
    output reg tick_out
);
    reg [4:0] count_reg;

    // Ratio changes take effect at once: the count is compared with the live
    // ratio_in, so lowering it can cut the current output period short.
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            count_reg <= 5'h00;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (!enable_in) begin
                count_reg <= 5'h00;
            end else if (tick_in) begin
                if (count_reg >= ratio_in) begin
                    count_reg <= 5'h00;
                    tick_out <= 1'b1;
                end else begin
                    count_reg <= count_reg + 5'h01;
                end
            end
        end
    end
endmodule // pcg_divider

`default_nettype wire

// >>> hw/pcg_pll_model.v
// Behavioural PLL: rate multiplier on reference ticks plus lock tracking.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_pll_model (
    input wire clk_in,
    input wire reset_in,
    input wire ref_tick_in,
    input wire pll_hold_in,
    input wire [4:0] mult_in,
    output reg out_tick_out,
    output reg locked_out
);
    reg [4:0] burst_reg;
    reg [15:0] lock_reg;

    // Each reference tick releases mult_in output ticks, one per cycle;
    // the system clock stands in for the analog oscillator.
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            burst_reg <= 5'h00;
            out_tick_out <= 1'b0;
            lock_reg <= 16'h0000;
            locked_out <= 1'b0;
        end else if (pll_hold_in) begin
            burst_reg <= 5'h00;
            out_tick_out <= 1'b0;
            lock_reg <= 16'h0000;
            locked_out <= 1'b0;
        end else begin
            if (ref_tick_in) begin
                burst_reg <= mult_in;
            end else if (burst_reg != 5'h00) begin
                burst_reg <= burst_reg - 5'h01;
            end
            out_tick_out <= ref_tick_in || (burst_reg > 5'h01);
            if (lock_reg < `PCG_LOCK_CYCLES) begin
                lock_reg <= lock_reg + 16'h0001;
            end
            locked_out <= (lock_reg >= `PCG_LOCK_CYCLES - 1);
        end
    end
endmodule // pcg_pll_model

`default_nettype wire

// >>> hw/pcg_top.v
// Clock generator controller: registers, reference select, post-dividers.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_top (
    input wire CLK_SYS_IN,
    input wire RESET_IN,
    input wire REF_CLOCK_PIN_TICK_IN,
    input wire MEM_CLOCK_IN_PIN_IN,
    input wire [31:0] ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire WRITE_IN,
    input wire READ_IN,
    output reg [31:0] RDATA_OUT,
    output reg CORE_CLOCK_OUT,
    output reg PERIPH_CLOCK_OUT,
    output reg MEM_SYS_CLOCK_OUT,
    output reg CLKOUT_B_PIN_OUT,
    output reg CLKOUT_C_PIN_OUT,
    output reg MEM_CLOCK_OUT_PIN_OUT,
    output reg PLL_POWERDOWN_OUT,
    output reg PLL_RESET_OUT
);
    // -------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------
    reg pll_path_select_reg;
    reg pll_powerdown_reg;
    reg pll_reset_ctl_reg;
    reg [4:0] mult_reg;
    reg [4:0] div_ratio_reg [0:4];
    reg [4:0] div_en_reg;
    reg mem_clk_source_sel_reg;
    reg clkout_b_gate_reg;
    reg mem_clk_out_enable_reg;
    reg [15:0] stable_cnt_reg;
    reg stable_reg;
    reg path_active_reg;
    reg [31:0] rdata_next;

    wire ref_tick;
    wire pre_tick;
    wire pll_tick;
    wire mult_code_ok;
    wire hf_tick;
    wire [4:0] div_tick;
    wire pll_hold;

    // Index 0 prescaler, 1 core, 2 periph, 3 memory, 4 oscillator.
    wire [4:0] div_src;
    assign ref_tick = REF_CLOCK_PIN_TICK_IN;
    assign pll_hold = pll_reset_ctl_reg | pll_powerdown_reg;
    // Reserved multiplier codes are refused and the old factor stays,
    // so a stray write can never push the PLL outside its range.
    assign mult_code_ok = (WDATA_IN[4:0] >= `PCG_MULT_MIN) &&
                          (WDATA_IN[4:0] <= `PCG_MULT_MAX);

    // -------------------------------------------------------------------
    // Stable counter
    // -------------------------------------------------------------------
    // The flag only ever sets. Once the reference has been counted it
    // stays up until the next reset, so software polling it can never
    // see it drop back while the reference keeps running.
    always @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            stable_cnt_reg <= 16'h0000;
            stable_reg <= 1'b0;
        end else begin
            if (stable_cnt_reg != `PCG_STABLE_CYCLES) begin
                if (ref_tick) begin
                    stable_cnt_reg <= stable_cnt_reg + 16'h0001;
                end
            end else begin
                stable_reg <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------
    always @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            pll_path_select_reg <= 1'b0;
            pll_powerdown_reg <= 1'b0;
            pll_reset_ctl_reg <= 1'b1;
            mult_reg <= `PCG_RST_MULT;
            div_ratio_reg[0] <= `PCG_RST_DIV0;
            div_ratio_reg[1] <= `PCG_RST_DIV1;
            div_ratio_reg[2] <= `PCG_RST_DIV2;
            div_ratio_reg[3] <= `PCG_RST_DIV3;
            div_ratio_reg[4] <= `PCG_RST_OSCDIV;
            div_en_reg <= 5'h1F;
            mem_clk_source_sel_reg <= 1'b0;
            clkout_b_gate_reg <= 1'b1;
            mem_clk_out_enable_reg <= 1'b1;
        end else if (WRITE_IN) begin
            case (ADDR_IN)
                `PCG_OFS_CSR: begin
                    pll_path_select_reg <= WDATA_IN[`PCG_CSR_PATH];
                    pll_powerdown_reg <= WDATA_IN[`PCG_CSR_PWRDN];
                    pll_reset_ctl_reg <= WDATA_IN[`PCG_CSR_RST];
                end
                `PCG_OFS_MULT: begin
                    if (mult_code_ok) begin
                        mult_reg <= WDATA_IN[4:0];
                    end
                end
                `PCG_OFS_DIV0: begin
                    div_ratio_reg[0] <= WDATA_IN[4:0];
                    div_en_reg[0] <= WDATA_IN[`PCG_DIV_EN];
                end
                `PCG_OFS_DIV1: begin
                    div_ratio_reg[1] <= WDATA_IN[4:0];
                    div_en_reg[1] <= WDATA_IN[`PCG_DIV_EN];
                end
                `PCG_OFS_DIV2: begin
                    div_ratio_reg[2] <= WDATA_IN[4:0];
                    div_en_reg[2] <= WDATA_IN[`PCG_DIV_EN];
                end
                `PCG_OFS_DIV3: begin
                    div_ratio_reg[3] <= WDATA_IN[4:0];
                    div_en_reg[3] <= WDATA_IN[`PCG_DIV_EN];
                end
                `PCG_OFS_OSCDIV: begin
                    div_ratio_reg[4] <= WDATA_IN[4:0];
                    div_en_reg[4] <= WDATA_IN[`PCG_DIV_EN];
                end
                `PCG_OFS_DEVCONF: begin
                    mem_clk_source_sel_reg <= WDATA_IN[`PCG_DEVCONF_SRC];
                end
                `PCG_OFS_MEMCTL: begin
                    clkout_b_gate_reg <= WDATA_IN[`PCG_MEMCTL_CKB];
                    mem_clk_out_enable_reg <= WDATA_IN[`PCG_MEMCTL_MEM];
                end
                default: begin
                    // Unmapped addresses take no write.
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------------
    always @* begin
        rdata_next = 32'h00000000;
        case (ADDR_IN)
            `PCG_OFS_CSR: begin
                rdata_next[`PCG_CSR_STABLE] = stable_reg;
                rdata_next[`PCG_CSR_RST] = pll_reset_ctl_reg;
                rdata_next[`PCG_CSR_PWRDN] = pll_powerdown_reg;
                rdata_next[`PCG_CSR_PATH] = pll_path_select_reg;
            end
            `PCG_OFS_MULT: rdata_next[4:0] = mult_reg;
            `PCG_OFS_DIV0: rdata_next = {16'h0000, div_en_reg[0],
                                         10'h000, div_ratio_reg[0]};
            `PCG_OFS_DIV1: rdata_next = {16'h0000, div_en_reg[1],
                                         10'h000, div_ratio_reg[1]};
            `PCG_OFS_DIV2: rdata_next = {16'h0000, div_en_reg[2],
                                         10'h000, div_ratio_reg[2]};
            `PCG_OFS_DIV3: rdata_next = {16'h0000, div_en_reg[3],
                                         10'h000, div_ratio_reg[3]};
            `PCG_OFS_OSCDIV: rdata_next = {16'h0000, div_en_reg[4],
                                           10'h000, div_ratio_reg[4]};
            `PCG_OFS_DEVCONF: rdata_next[`PCG_DEVCONF_SRC] =
                mem_clk_source_sel_reg;
            `PCG_OFS_MEMCTL: begin
                rdata_next[`PCG_MEMCTL_CKB] = clkout_b_gate_reg;
                rdata_next[`PCG_MEMCTL_MEM] = mem_clk_out_enable_reg;
            end
            default: rdata_next = 32'h00000000;
        endcase
    end

    // -------------------------------------------------------------------
    // Read data register
    // -------------------------------------------------------------------
    // Read data stand for one cycle only and return to zero, so a stale
    // value is never mistaken for a fresh one.
    always @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            RDATA_OUT <= 32'h00000000;
        end else begin
            RDATA_OUT <= READ_IN ? rdata_next : 32'h00000000;
        end
    end

    // -------------------------------------------------------------------
    // PLL path and reference select
    // -------------------------------------------------------------------
    // The lock flag stays inside the model: software times the lock wait
    // itself, so nothing here depends on it.
    pcg_pll_model u_pll (
        .clk_in(CLK_SYS_IN),
        .reset_in(RESET_IN),
        .ref_tick_in(pre_tick),
        .pll_hold_in(pll_hold),
        .mult_in(mult_reg),
        .out_tick_out(pll_tick),
        .locked_out()
    );

    // The select bit is taken only when no tick is pending from either source;
    // setting the PLL reset bit drops back to the reference path at once.
    always @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            path_active_reg <= 1'b0;
        end else if (pll_reset_ctl_reg) begin
            path_active_reg <= 1'b0;
        end else if (!ref_tick && !pll_tick) begin
            path_active_reg <= pll_path_select_reg;
        end
    end

    assign hf_tick = path_active_reg ? pll_tick : ref_tick;

    // -------------------------------------------------------------------
    // Dividers
    // -------------------------------------------------------------------
    assign div_src = {ref_tick, hf_tick, hf_tick, hf_tick, ref_tick};

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : gen_div
            pcg_divider u_div (
                .clk_in(CLK_SYS_IN),
                .reset_in(RESET_IN),
                .tick_in(div_src[g]),
                .enable_in(div_en_reg[g]),
                .ratio_in(div_ratio_reg[g]),
                .tick_out(div_tick[g])
            );
        end
    endgenerate

    assign pre_tick = div_tick[0];

    // -------------------------------------------------------------------
    // Clock outputs, one register stage each
    // -------------------------------------------------------------------
    always @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            CORE_CLOCK_OUT <= 1'b0;
            PERIPH_CLOCK_OUT <= 1'b0;
            MEM_SYS_CLOCK_OUT <= 1'b0;
            CLKOUT_B_PIN_OUT <= 1'b0;
            CLKOUT_C_PIN_OUT <= 1'b0;
            MEM_CLOCK_OUT_PIN_OUT <= 1'b0;
        end else begin
            CORE_CLOCK_OUT <= div_tick[1];
            PERIPH_CLOCK_OUT <= div_tick[2];
            MEM_SYS_CLOCK_OUT <= div_tick[3];
            CLKOUT_B_PIN_OUT <= div_tick[2] & div_en_reg[2] &
                                clkout_b_gate_reg;
            CLKOUT_C_PIN_OUT <= div_tick[4] & div_en_reg[4];
            MEM_CLOCK_OUT_PIN_OUT <= mem_clk_out_enable_reg &
                (mem_clk_source_sel_reg ? MEM_CLOCK_IN_PIN_IN
                                        : div_tick[3]);
        end
    end

    // -------------------------------------------------------------------
    // PLL control pins
    // -------------------------------------------------------------------
    // The pins mirror the register bits one cycle late, like every other
    // output, so the analog side never sees a combinational glitch.
    always @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            PLL_POWERDOWN_OUT <= 1'b0;
            PLL_RESET_OUT <= 1'b1;
        end else begin
            PLL_POWERDOWN_OUT <= pll_powerdown_reg;
            PLL_RESET_OUT <= pll_reset_ctl_reg;
        end
    end
endmodule // pcg_top

`default_nettype wire

// >>> tb/pcg_properties.sv
// Concurrent checks on the clock generator's register port and outputs.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_checker (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    input wire logic REF_CLOCK_PIN_TICK_IN,
    input wire logic [31:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WRITE_IN,
    input wire logic READ_IN,
    input wire logic [31:0] RDATA_OUT,
    input wire logic CORE_CLOCK_OUT,
    input wire logic PERIPH_CLOCK_OUT,
    input wire logic CLKOUT_B_PIN_OUT,
    input wire logic CLKOUT_C_PIN_OUT,
    input wire logic PLL_POWERDOWN_OUT,
    input wire logic PLL_RESET_OUT
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);
    // ----------------------------------------
    // Helper history
    // ----------------------------------------
    // Four cycles of reference history cover any pipeline depth up to four.
    logic [3:0] ref_hist_reg;
    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) ref_hist_reg <= 4'h0;
        else ref_hist_reg <= {ref_hist_reg[2:0], REF_CLOCK_PIN_TICK_IN};
    end
    sequence csr_write;
        WRITE_IN && ADDR_IN == `PCG_OFS_CSR;
    endsequence
    sequence read_of(logic [31:0] a);
        READ_IN && ADDR_IN == a;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    rdata_idle_a: assert property (
        !$past(READ_IN) |-> RDATA_OUT == 32'h0)
        else $error("read data not zero outside a read");
    csr_reserved_a: assert property (
        read_of(`PCG_OFS_CSR) |=> (RDATA_OUT & 32'hFFFFFFB4) == 32'h0)
        else $error("status reserved bits not zero");
    csr_mirror_a: assert property (
        read_of(`PCG_OFS_CSR) |=> RDATA_OUT[3] == PLL_RESET_OUT
            && RDATA_OUT[1] == PLL_POWERDOWN_OUT)
        else $error("status bits differ from pins");
    rst_copy_a: assert property (
        csr_write |-> ##2 PLL_RESET_OUT == $past(WDATA_IN[3], 2))
        else $error("reset pin does not follow write");
    pwrdn_copy_a: assert property (
        csr_write |-> ##2 PLL_POWERDOWN_OUT == $past(WDATA_IN[1], 2))
        else $error("powerdown pin does not follow write");
    mult_range_a: assert property (
        read_of(`PCG_OFS_MULT) |=> RDATA_OUT inside {[4:25]})
        else $error("multiplier outside four to twenty five");
    div_fields_a: assert property (
        READ_IN && ADDR_IN inside {`PCG_OFS_DIV0, `PCG_OFS_DIV1,
            `PCG_OFS_DIV2, `PCG_OFS_DIV3, `PCG_OFS_OSCDIV}
        |=> (RDATA_OUT & 32'hFFFF7FE0) == 32'h0)
        else $error("divider reserved bits not zero");
    clkb_periph_a: assert property (
        CLKOUT_B_PIN_OUT |-> PERIPH_CLOCK_OUT)
        else $error("second clock pin without peripheral tick");
    clkc_ref_a: assert property (
        $rose(CLKOUT_C_PIN_OUT) |-> |ref_hist_reg)
        else $error("third clock pin without reference tick");
    bypass_core_a: assert property (
        CORE_CLOCK_OUT && PLL_RESET_OUT && $past(PLL_RESET_OUT, 4)
        |-> |ref_hist_reg)
        else $error("core tick not from reference in reset");
endmodule // pcg_checker
bind pcg_top pcg_checker u_chk (.CLK_SYS_IN, .RESET_IN,
    .REF_CLOCK_PIN_TICK_IN, .ADDR_IN, .WDATA_IN, .WRITE_IN, .READ_IN,
    .RDATA_OUT, .CORE_CLOCK_OUT, .PERIPH_CLOCK_OUT, .CLKOUT_B_PIN_OUT,
    .CLKOUT_C_PIN_OUT, .PLL_POWERDOWN_OUT, .PLL_RESET_OUT);
`default_nettype wire

// >>> tb/pcg_top_tb_top.sv
// Self-checking bench for the clock generator controller.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_top_tb_top;
    logic CLK_SYS_IN, RESET_IN, MEM_CLOCK_IN_PIN_IN;
    logic REF_CLOCK_PIN_TICK_IN = 1'b0;
    logic [31:0] ADDR_IN, WDATA_IN, RDATA_OUT, rd_val;
    logic WRITE_IN, READ_IN, CORE_CLOCK_OUT, PERIPH_CLOCK_OUT;
    logic MEM_SYS_CLOCK_OUT, CLKOUT_B_PIN_OUT, CLKOUT_C_PIN_OUT;
    logic MEM_CLOCK_OUT_PIN_OUT, PLL_POWERDOWN_OUT, PLL_RESET_OUT;
    logic [2:0] ref_phase = 3'h0;
    int fail_count, tests_run;
    int cnt[6];
    // Reference ticks in one counting window, and the PLL ticks at x7.
    localparam int T = 1280 / 8;
    localparam int P = T * 7;
    string nm[6] = '{"core", "periph", "mem_sys", "clkb", "clkc", "memout"};
    logic [31:0] map_a[10] = '{`PCG_OFS_CSR, `PCG_OFS_MULT, `PCG_OFS_DIV0,
        `PCG_OFS_DIV1, `PCG_OFS_DIV2, `PCG_OFS_DIV3, `PCG_OFS_OSCDIV,
        `PCG_OFS_DEVCONF, `PCG_OFS_MEMCTL, 32'h01B7C104};
    logic [31:0] map_r[10] = '{32'h8, 32'h7, 32'h8000, 32'h8000,
        32'h8001, 32'h8001, 32'h8000, 32'h0, 32'h28, 32'h0};
    logic [31:0] mw[5] = '{32'h3, 32'h1A, 32'h19, 32'h4, 32'h7};
    logic [31:0] mr[5] = '{32'h7, 32'h7, 32'h19, 32'h4, 32'h7};

    pcg_top uut (.CLK_SYS_IN, .RESET_IN, .REF_CLOCK_PIN_TICK_IN,
        .MEM_CLOCK_IN_PIN_IN, .ADDR_IN, .WDATA_IN, .WRITE_IN, .READ_IN,
        .RDATA_OUT, .CORE_CLOCK_OUT, .PERIPH_CLOCK_OUT, .MEM_SYS_CLOCK_OUT,
        .CLKOUT_B_PIN_OUT, .CLKOUT_C_PIN_OUT, .MEM_CLOCK_OUT_PIN_OUT,
        .PLL_POWERDOWN_OUT, .PLL_RESET_OUT);

    initial begin
        CLK_SYS_IN = 1'b0;
        forever #50 CLK_SYS_IN = ~CLK_SYS_IN;
    end
    // One tick every eight cycles keeps each x7 burst shorter than the gap.
    always @(posedge CLK_SYS_IN) begin
        ref_phase <= ref_phase + 3'h1;
        REF_CLOCK_PIN_TICK_IN <= (ref_phase == 3'h7);
    end
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic complete_run;
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge CLK_SYS_IN);
        ADDR_IN <= a;
        WDATA_IN <= d;
        WRITE_IN <= 1'b1;
        @(posedge CLK_SYS_IN);
        WRITE_IN <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge CLK_SYS_IN);
        ADDR_IN <= a;
        READ_IN <= 1'b1;
        @(posedge CLK_SYS_IN);
        READ_IN <= 1'b0;
        #1;
        rd_val = RDATA_OUT;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), e, rd_val);
    endtask
    // Counts are taken over whole output periods once the dividers settle.
    task automatic win(input int e[6]);
        logic [5:0] s;
        foreach (cnt[i]) cnt[i] = 0;
        repeat (600) @(posedge CLK_SYS_IN);
        repeat (1280) begin
            @(negedge CLK_SYS_IN);
            s = {MEM_CLOCK_OUT_PIN_OUT, CLKOUT_C_PIN_OUT, CLKOUT_B_PIN_OUT,
                 MEM_SYS_CLOCK_OUT, PERIPH_CLOCK_OUT, CORE_CLOCK_OUT};
            foreach (cnt[i]) cnt[i] += s[i];
        end
        foreach (cnt[i]) chk(nm[i], e[i], cnt[i]);
    endtask
    task automatic lvl(input logic v, input logic e);
        @(posedge CLK_SYS_IN);
        MEM_CLOCK_IN_PIN_IN <= v;
        repeat (4) @(posedge CLK_SYS_IN);
        #1;
        chk("memout", {31'h0, e}, {31'h0, MEM_CLOCK_OUT_PIN_OUT});
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (50000) @(posedge CLK_SYS_IN);
        fail_count++;
        complete_run;
    end
    initial begin
        RESET_IN = 1'b1;
        {WRITE_IN, READ_IN, MEM_CLOCK_IN_PIN_IN} = 3'h0;
        {ADDR_IN, WDATA_IN} = 64'h0;
        fail_count = 0;
        tests_run = 0;
        repeat (3) @(posedge CLK_SYS_IN);
        RESET_IN <= 1'b0;
        for (int i = 0; i < 10; i++) rdc(map_a[i], map_r[i]);
        chk("rst pin", 32'h1, {31'h0, PLL_RESET_OUT});
        for (int i = 0; i < 400 && rd_val[6] !== 1'b1; i++) begin
            repeat (6) @(posedge CLK_SYS_IN);
            rd(`PCG_OFS_CSR);
        end
        if (rd_val[6] !== 1'b1) begin
            fail_count++;
            complete_run;
        end
        wr(`PCG_OFS_CSR, 32'hFFFFFFFC);
        rdc(`PCG_OFS_CSR, 32'h48);
        wr(`PCG_OFS_CSR, 32'hA);
        rdc(`PCG_OFS_CSR, 32'h4A);
        chk("pwrdn pin", 32'h1, {31'h0, PLL_POWERDOWN_OUT});
        wr(`PCG_OFS_CSR, 32'h8);
        for (int i = 0; i < 5; i++) begin
            wr(`PCG_OFS_MULT, mw[i]);
            rdc(`PCG_OFS_MULT, mr[i]);
        end
        wr(`PCG_OFS_CSR, 32'h9);
        rdc(`PCG_OFS_CSR, 32'h49);
        win('{T, T / 2, T / 2, T / 2, T, T / 2});
        wr(`PCG_OFS_DIV2, 32'h8009);
        wr(`PCG_OFS_DIV1, 32'h8004);
        wr(`PCG_OFS_DIV3, 32'h8003);
        wr(`PCG_OFS_OSCDIV, 32'h801F);
        wr(`PCG_OFS_MEMCTL, 32'h20);
        win('{T / 5, T / 10, T / 4, 0, T / 32, T / 4});
        wr(`PCG_OFS_MEMCTL, 32'h8);
        wr(`PCG_OFS_OSCDIV, 32'h1F);
        wr(`PCG_OFS_DEVCONF, 32'h10);
        lvl(1'b1, 1'b0);
        win('{T / 5, T / 10, T / 4, T / 10, 0, 0});
        wr(`PCG_OFS_MEMCTL, 32'h28);
        lvl(1'b1, 1'b1);
        lvl(1'b0, 1'b0);
        wr(`PCG_OFS_DEVCONF, 32'h0);
        wr(`PCG_OFS_DIV1, 32'h8000);
        wr(`PCG_OFS_DIV2, 32'h8001);
        wr(`PCG_OFS_CSR, 32'h0);
        repeat (1900) @(posedge CLK_SYS_IN);
        wr(`PCG_OFS_CSR, 32'h1);
        rdc(`PCG_OFS_CSR, 32'h41);
        win('{P, P / 2, P / 4, P / 2, 0, P / 4});
        wr(`PCG_OFS_CSR, 32'h0);
        wr(`PCG_OFS_CSR, 32'h2);
        rdc(`PCG_OFS_CSR, 32'h42);
        chk("pwrdn pin", 32'h1, {31'h0, PLL_POWERDOWN_OUT});
        chk("rst pin", 32'h0, {31'h0, PLL_RESET_OUT});
        complete_run;
    end
endmodule // pcg_top_tb_top
`default_nettype wire
